/* File: rtl/correcting_approx_register.sv */
// error-correcting successive approximation register
// assumes comparator_i high means input at or above the dac code
`timescale 1ns/100ps
`default_nettype none
`include "sar_ctrl_consts.svh"
module correcting_approx_register (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic comparator_i,
    output sar_ctrl_pkg::code_t dac_code_o,
    output logic dac_settle_fine_o,
    sar_if.seq sif
);
    import sar_ctrl_pkg::*;

    function automatic coarse_t nudge(input coarse_t c, input logic up);
        nudge = up ? c + 8'h01 : c - 8'h01;
    endfunction : nudge

    seq_state_t state_q, state_d;
    code_t code_q, code_d, result_q, result_d;
    bit_idx_t idx_q, idx_d;
    coarse_t cor_q, cor_d, coarse_q, coarse_d;
    logic up_q, up_d, eight_q, eight_d, done_q, done_d, fine_q, fine_d;

    always_comb begin
        state_d = state_q;
        code_d = code_q;
        idx_d = idx_q;
        cor_d = cor_q;
        coarse_d = coarse_q;
        up_d = up_q;
        eight_d = eight_q;
        done_d = 1'b0;
        result_d = result_q;
        case (state_q)
            ST_IDLE: begin
                if (sif.start) begin
                    state_d = ST_COARSE;
                    code_d = `MSB_TRIAL;
                    idx_d = bit_idx_t'(`CODE_MSB);
                    eight_d = sif.eight_bit;
                end
            end
            ST_COARSE: begin
                if (sif.step) begin
                    if (!comparator_i) code_d[idx_q] = 1'b0;
                    if (idx_q == bit_idx_t'(`COARSE_LSB)) begin
                        coarse_d = code_d[`CODE_MSB:`COARSE_LSB];
                        cor_d = code_d[`CODE_MSB:`COARSE_LSB];
                        if (eight_q) begin
                            // short cycle: no correction, no fine bits
                            state_d = ST_IDLE;
                            done_d = 1'b1;
                            result_d = {code_d[`CODE_MSB:`COARSE_LSB], `EIGHT_TAIL};
                        end else begin
                            state_d = ST_CORR1;
                        end
                    end else begin
                        idx_d = idx_q - bit_idx_t'(1);
                        code_d[idx_d] = 1'b1;
                    end
                end
            end
            ST_CORR1: begin
                if (sif.step) begin
                    // first check at the code's lower edge picks the direction
                    up_d = comparator_i;
                    if (comparator_i ? (cor_q != `COARSE_TOP) : (cor_q != '0)) begin
                        code_d = {nudge(cor_q, comparator_i), 4'h0};
                        if (!comparator_i) cor_d = nudge(cor_q, 1'b0);
                    end
                    state_d = ST_CORR2;
                end
            end
            ST_CORR2: begin
                if (sif.step) begin
                    if (up_q ? (comparator_i && cor_q != `COARSE_TOP) : (!comparator_i && cor_q != '0)) begin
                        cor_d = nudge(cor_q, up_q);
                    end
                    code_d = {cor_d, `FINE_TRIAL};
                    idx_d = bit_idx_t'(`FINE_MSB);
                    state_d = ST_FINE;
                end
            end
            ST_FINE: begin
                if (sif.step) begin
                    // fine bits only ever add to the corrected value
                    if (!comparator_i) code_d[idx_q] = 1'b0;
                    if (idx_q == '0) begin
                        state_d = ST_IDLE;
                        done_d = 1'b1;
                        result_d = code_d;
                    end else begin
                        idx_d = idx_q - bit_idx_t'(1);
                        code_d[idx_d] = 1'b1;
                    end
                end
            end
            default: state_d = ST_IDLE;
        endcase
        fine_d = (state_d == ST_CORR1) || (state_d == ST_CORR2) || (state_d == ST_FINE);
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
            code_q <= '0;
            idx_q <= '0;
            cor_q <= '0;
            coarse_q <= '0;
            up_q <= 1'b0;
            eight_q <= 1'b0;
            done_q <= 1'b0;
            result_q <= '0;
            fine_q <= 1'b0;
        end else begin
            state_q <= state_d;
            code_q <= code_d;
            idx_q <= idx_d;
            cor_q <= cor_d;
            coarse_q <= coarse_d;
            up_q <= up_d;
            eight_q <= eight_d;
            done_q <= done_d;
            result_q <= result_d;
            fine_q <= fine_d;
        end
    end

    assign dac_code_o = code_q;
    assign dac_settle_fine_o = fine_q;
    assign sif.done = done_q;
    assign sif.result = result_q;
    assign sif.fine_next = fine_d;
    assign sif.active = (state_q != ST_IDLE);

    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    short_stop_a: assert property (state_q == ST_COARSE && sif.step && eight_q
        && idx_q == bit_idx_t'(`COARSE_LSB) |=> state_q == ST_IDLE && done_q && result_q[3:0] == `EIGHT_TAIL)
        else $error("eight-bit conversion did not stop after coarse bits");
    corr_pair_a: assert property (state_q == ST_CORR1 && sif.step
        |=> (state_q == ST_CORR2 && !sif.step) [*6] ##1 (state_q == ST_CORR2 && sif.step) ##1 state_q == ST_FINE)
        else $error("correction cycles not exactly two");
    corr_range_a: assert property (state_q == ST_FINE |->
        (9'(cor_q) + 9'h2 >= 9'(coarse_q)) && (9'(cor_q) <= 9'(coarse_q) + 9'h1))
        else $error("correction moved coarse code out of range");
    settle_mode_a: assert property (dac_settle_fine_o == (state_q inside {ST_CORR1, ST_CORR2, ST_FINE}))
        else $error("dac settling mode wrong for phase");
    coarse_fast_a: assert property (state_q == ST_COARSE |-> !dac_settle_fine_o)
        else $error("coarse decisions not on fast settling");
    fine_raise_a: assert property (state_q == ST_FINE |-> code_q[11:4] == cor_q)
        else $error("fine decisions changed the corrected value");
endmodule : correcting_approx_register
`default_nettype wire

/* File: rtl/error_correcting_sar_control.sv */
// control top: start decoding, result readout, Avalon-MM registers, interrupt
// assumes all pins synchronous to sys_clk_i; comparator and dac are outside
`timescale 1ns/100ps
`default_nettype none
`include "sar_ctrl_consts.svh"
// Overview of operation
// - eight coarse decisions fast, 8-bit settling
// - exactly two correction cycles follow coarse
// - correction moves code one up, two down
// - four fine decisions at full settling
// - fine decisions only raise the code
// - processor control or stand-alone mode
// - read 12 bits or 8 then 4
// - straight binary result code
// - start when enable, select, convert all true
// - busy only converting; outputs off; restart ignored
// - drive only when reading; byte layout
// - latch byte-select; eight-bit result tail 1000
module error_correcting_sar_control (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [4:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [31:0] writedata_i,
    input wire logic [3:0] byteenable_i,
    output logic [31:0] readdata_o,
    output logic waitrequest_o,
    output logic irq_o,
    input wire logic chip_enable_i,
    input wire logic chip_select_n_i,
    input wire logic read_convert_i,
    input wire logic full_width_i,
    input wire logic byte_select_i,
    input wire logic comparator_i,
    output logic conversion_busy_o,
    output sar_ctrl_pkg::code_t data_o,
    output logic [2:0] data_oe_n_o,
    output sar_ctrl_pkg::code_t dac_code_o,
    output logic dac_settle_fine_o
);
    import sar_ctrl_pkg::*;

    sar_if sif ();

    correcting_approx_register u_sar (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .comparator_i(comparator_i),
        .dac_code_o(dac_code_o),
        .dac_settle_fine_o(dac_settle_fine_o),
        .sif(sif.seq)
    );

    step_timer u_timer (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .tif(sif.timer)
    );

    function automatic logic [31:0] reg_read(input logic [4:0] addr, input logic alone,
        input logic [2:0] stat, input code_t res, input logic [1:0] ist, input logic [1:0] imask);
        case (addr)
            `REG_CTRL: reg_read = {31'h0, alone};
            `REG_STATUS: reg_read = {29'h0, stat};
            `REG_RESULT: reg_read = {20'h0, res};
            `REG_IRQ_STAT: reg_read = {30'h0, ist};
            `REG_IRQ_MASK: reg_read = {30'h0, imask};
            default: reg_read = 32'h0;
        endcase
    endfunction : reg_read

    // control pin state
    logic alone_q, alone_d;
    logic prev_start_q, prev_start_d;
    logic busy_q, busy_d;
    logic eight_q, eight_d;
    logic valid_q, valid_d;
    code_t result_q, result_d;
    code_t data_q, data_d;
    logic [2:0] oe_n_q, oe_n_d;

    // bus and interrupt state
    logic wait_q, wait_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] irq_stat_q, irq_stat_d;
    logic [1:0] irq_mask_q, irq_mask_d;
    logic irq_q, irq_d;

    logic ce_eff, sel_eff, a0_eff, wide_eff;
    logic start_lvl, start_edge, start_go, start_lost;
    logic rd_en;
    logic bus_acc, wr_commit;
    logic [2:0] stat_bits;

    // stand-alone forces the other control inputs to their strapped levels
    assign ce_eff = alone_q | chip_enable_i;
    assign sel_eff = alone_q | ~chip_select_n_i;
    assign a0_eff = ~alone_q & byte_select_i;
    assign wide_eff = alone_q | full_width_i;

    // last of the three inputs to arrive starts the conversion
    assign start_lvl = ce_eff & sel_eff & ~read_convert_i;
    assign start_edge = start_lvl & ~prev_start_q;
    assign start_go = start_edge & ~busy_q;
    assign start_lost = start_edge & busy_q;

    assign sif.start = start_go;
    assign sif.eight_bit = a0_eff;

    assign stat_bits = {valid_q, eight_q, busy_q};

    always_comb begin
        alone_d = alone_q;
        prev_start_d = start_lvl;
        busy_d = busy_q;
        eight_d = eight_q;
        valid_d = valid_q;
        result_d = result_q;
        if (start_go) begin
            busy_d = 1'b1;
            eight_d = a0_eff;
            valid_d = 1'b0;
        end else if (sif.done) begin
            // busy drops on the same edge the code is captured
            busy_d = 1'b0;
            valid_d = 1'b1;
            result_d = sif.result;
        end
        if (wr_commit && address_i == `REG_CTRL) alone_d = writedata_i[`CTRL_ALONE_BIT];
    end

    // readout drive, computed from next busy so no old data leaks at start
    assign rd_en = read_convert_i & ~busy_d & ce_eff & sel_eff;

    always_comb begin
        data_d = result_d;
        oe_n_d = `OE_ALL_OFF;
        if (rd_en) begin
            if (wide_eff) begin
                oe_n_d = `OE_ALL_ON;
            end else if (!a0_eff) begin
                oe_n_d = `OE_MSB_BYTE;
            end else begin
                // low byte: four zeros on the shared lines above the four lsbs
                oe_n_d = `OE_LSB_BYTE;
                data_d[7:4] = 4'h0;
            end
        end
    end

    // Avalon: one wait cycle per access, then waitrequest low for one edge
    assign bus_acc = (read_i | write_i) & wait_q;
    assign wr_commit = write_i & ~wait_q & byteenable_i[0];

    always_comb begin
        wait_d = ~bus_acc;
        rdata_d = rdata_q;
        if (bus_acc && read_i) begin
            rdata_d = reg_read(address_i, alone_q, stat_bits, result_q, irq_stat_q, irq_mask_q);
        end
        irq_mask_d = irq_mask_q;
        irq_stat_d = irq_stat_q;
        if (wr_commit && address_i == `REG_IRQ_MASK) irq_mask_d = writedata_i[1:0];
        if (wr_commit && address_i == `REG_IRQ_STAT) irq_stat_d = irq_stat_q & ~writedata_i[1:0];
        // a new event beats a clear in the same cycle
        if (sif.done) irq_stat_d[`IRQ_DONE_BIT] = 1'b1;
        if (start_lost) irq_stat_d[`IRQ_IGNORED_BIT] = 1'b1;
        irq_d = |(irq_stat_d & irq_mask_d);
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            alone_q <= 1'b0;
            // seeded high so a start level held through reset needs a fresh edge
            prev_start_q <= 1'b1;
            busy_q <= 1'b0;
            eight_q <= 1'b0;
            valid_q <= 1'b0;
            result_q <= '0;
            data_q <= '0;
            oe_n_q <= `OE_ALL_OFF;
        end else begin
            alone_q <= alone_d;
            prev_start_q <= prev_start_d;
            busy_q <= busy_d;
            eight_q <= eight_d;
            valid_q <= valid_d;
            result_q <= result_d;
            data_q <= data_d;
            oe_n_q <= oe_n_d;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            wait_q <= 1'b1;
            rdata_q <= '0;
            irq_stat_q <= '0;
            irq_mask_q <= '0;
            irq_q <= 1'b0;
        end else begin
            wait_q <= wait_d;
            rdata_q <= rdata_d;
            irq_stat_q <= irq_stat_d;
            irq_mask_q <= irq_mask_d;
            irq_q <= irq_d;
        end
    end

    assign readdata_o = rdata_q;
    assign waitrequest_o = wait_q;
    assign irq_o = irq_q;
    assign conversion_busy_o = busy_q;
    assign data_o = data_q;
    assign data_oe_n_o = oe_n_q;

    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    start_busy_a: assert property (start_lvl && !prev_start_q && !busy_q
        |=> conversion_busy_o && eight_q == $past(a0_eff))
        else $error("start request did not raise busy");

    busy_hiz_a: assert property (conversion_busy_o |-> data_oe_n_o == 3'h7)
        else $error("data driven while converting");

    restart_ignored_a: assert property (busy_q && !sif.done |=> busy_q && $stable(eight_q))
        else $error("conversion restarted while busy");

    lsb_byte_a: assert property (data_oe_n_o == 3'h4 |-> data_o[7:4] == 4'h0
        && data_o[3:0] == result_q[3:0])
        else $error("low byte readout layout wrong");

    read_gate_a: assert property (data_oe_n_o != 3'h7 |-> $past(read_convert_i) && !conversion_busy_o)
        else $error("data driven outside a read");

    wide_read_a: assert property (data_oe_n_o == 3'h0 |-> data_o == result_q)
        else $error("full width read does not show result");

    done_latch_a: assert property (sif.done |=> !conversion_busy_o && result_q == $past(sif.result)
        && valid_q)
        else $error("busy not cleared with result capture");

    bus_answer_a: assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o ##1 waitrequest_o)
        else $error("bus answer not one cycle");

    // line follows the registered flags in the same cycle; mask writes are checked by mask_write_a
    irq_level_a: assert property (irq_o == |(irq_stat_q & irq_mask_q))
        else $error("interrupt level mismatch");

    // stand-alone straps the other inputs, so every start is a full one
    alone_start_a: assert property (alone_q && !read_convert_i && !prev_start_q && !busy_q
        |=> conversion_busy_o && !eight_q)
        else $error("stand-alone start not a full conversion");

    no_spurious_a: assert property (!busy_q && !start_go |=> !conversion_busy_o)
        else $error("busy rose without a start request");

    valid_start_a: assert property (start_go |=> !valid_q)
        else $error("old result still marked valid");

    msb_byte_a: assert property (data_oe_n_o == `OE_MSB_BYTE |-> data_o[11:4] == result_q[11:4])
        else $error("high byte readout layout wrong");

    // events win over a clear written in the same cycle
    lost_flag_a: assert property (start_lost |=> irq_stat_q[`IRQ_IGNORED_BIT])
        else $error("ignored start not flagged");

    done_flag_a: assert property (sif.done |=> irq_stat_q[`IRQ_DONE_BIT])
        else $error("finished conversion not flagged");

    mask_write_a: assert property (wr_commit && address_i == `REG_IRQ_MASK
        |=> irq_mask_q == $past(writedata_i[1:0]))
        else $error("interrupt mask write lost");

    // a write without lane zero must not touch any field
    lane_refused_a: assert property (write_i && !waitrequest_o && !byteenable_i[0]
        |=> $stable(alone_q) && $stable(irq_mask_q))
        else $error("write without lane zero took effect");

    ctrl_read_a: assert property (read_i && waitrequest_o && address_i == `REG_CTRL
        |=> readdata_o == {31'h0, $past(alone_q)})
        else $error("control read returned wrong value");

    status_read_a: assert property (read_i && waitrequest_o && address_i == `REG_STATUS
        |=> readdata_o == {29'h0, $past(stat_bits)})
        else $error("status read returned wrong bits");

    result_read_a: assert property (read_i && waitrequest_o && address_i == `REG_RESULT
        |=> readdata_o == {20'h0, $past(result_q)})
        else $error("result read returned wrong code");

    // holes in the map read as zero so software can probe safely
    unmapped_read_a: assert property (read_i && waitrequest_o && !(address_i inside {`REG_CTRL, `REG_STATUS,
        `REG_RESULT, `REG_IRQ_STAT, `REG_IRQ_MASK}) |=> readdata_o == 32'h0)
        else $error("unmapped read not zero");
endmodule : error_correcting_sar_control
`default_nettype wire

/* File: rtl/step_timer.sv */
// decision pacing: one-cycle step enables, short in coarse phase, long in fine phase
// assumes sar_if and the step constants
`timescale 1ns/100ps
`default_nettype none
`include "sar_ctrl_consts.svh"
module step_timer (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    sar_if.timer tif
);
    import sar_ctrl_pkg::*;

    function automatic step_cnt_t period(input logic fine);
        period = fine ? step_cnt_t'(`FINE_STEP_CYC) : step_cnt_t'(`COARSE_STEP_CYC);
    endfunction : period

    step_cnt_t cnt_q, cnt_d;

    assign tif.step = (cnt_q == step_cnt_t'(1));

    always_comb begin
        cnt_d = cnt_q - step_cnt_t'(1);
        if (tif.start) begin
            cnt_d = period(1'b0);
        end else if (!tif.active) begin
            cnt_d = '0;
        end else if (tif.step) begin
            // next phase decides how long the dac gets to settle
            cnt_d = period(tif.fine_next);
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule : step_timer
`default_nettype wire

/* File: shared/sar_ctrl_consts.svh */
// named constants for the correcting converter sequencer
// assumes a 10 MHz system clock and a word-aligned Avalon-MM map
`ifndef SAR_CTRL_CONSTS_SVH
`define SAR_CTRL_CONSTS_SVH
`define CLK_PERIOD_NS 100
`define COARSE_STEP_NS 350
`define FINE_STEP_NS 700
`define COARSE_STEP_CYC ((`COARSE_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FINE_STEP_CYC ((`FINE_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CODE_MSB 11
`define COARSE_LSB 4
`define FINE_MSB 3
`define MSB_TRIAL 12'h800
`define FINE_TRIAL 4'h8
`define EIGHT_TAIL 4'h8
`define COARSE_TOP 8'hFF
`define REG_CTRL 5'h00
`define REG_STATUS 5'h04
`define REG_RESULT 5'h08
`define REG_IRQ_STAT 5'h0C
`define REG_IRQ_MASK 5'h10
`define CTRL_ALONE_BIT 0
`define STAT_BUSY_BIT 0
`define STAT_EIGHT_BIT 1
`define STAT_VALID_BIT 2
`define IRQ_DONE_BIT 0
`define IRQ_IGNORED_BIT 1
`define OE_ALL_OFF 3'h7
`define OE_ALL_ON 3'h0
`define OE_MSB_BYTE 3'h1
`define OE_LSB_BYTE 3'h4
`endif

/* File: shared/sar_ctrl_pkg.sv */
// types shared by the converter sequencer files
// assumes sar_ctrl_consts.svh for the numeric constants
package sar_ctrl_pkg;
    typedef logic [11:0] code_t;
    typedef logic [7:0] coarse_t;
    typedef logic [3:0] bit_idx_t;
    typedef logic [2:0] step_cnt_t;
    typedef enum logic [2:0] {ST_IDLE, ST_COARSE, ST_CORR1, ST_CORR2, ST_FINE} seq_state_t;
endpackage : sar_ctrl_pkg

/* File: shared/sar_if.sv */
// link between control top, correcting register and step timer
// assumes one clock domain shared by all three
`timescale 1ns/100ps
`default_nettype none
interface sar_if;
    import sar_ctrl_pkg::*;
    logic start;
    logic eight_bit;
    logic step;
    logic fine_next;
    logic active;
    logic done;
    code_t result;
    modport ctrl (output start, output eight_bit, input done, input result);
    modport seq (input start, input eight_bit, input step, output done, output result,
                 output fine_next, output active);
    modport timer (input start, input fine_next, input active, output step);
endinterface : sar_if
`default_nettype wire

/* File: testbench/analog_source_model.sv */
// analog input in front of the comparator, still moving early in a conversion
// assumes busy marks a conversion and dac code is the live trial code
`timescale 1ns/100ps
`default_nettype none
module analog_source_model (
    input wire logic sys_clk_i,
    input wire logic busy_i,
    input wire logic [11:0] dac_code_i,
    input wire logic [11:0] early_i,
    input wire logic [11:0] final_i,
    output logic comparator_o
);
    logic [7:0] age_q;
    // settles after the coarse decisions, before the first correction decision
    always_ff @(posedge sys_clk_i) begin
        age_q <= busy_i ? ((age_q == 8'hFF) ? age_q : age_q + 8'h01) : 8'h00;
    end
    assign comparator_o = (((age_q < 8'h23) ? early_i : final_i) >= dac_code_i);
endmodule : analog_source_model
`default_nettype wire

/* File: testbench/error_correcting_sar_control_bench.sv */
// self-checking bench for the correcting converter control top
// assumes the analog source model on the comparator and Avalon-MM access
`timescale 1ns/100ps
`default_nettype none
`include "sar_ctrl_consts.svh"
module error_correcting_sar_control_bench;
    import sar_ctrl_pkg::*;
    logic sys_clk = 1'h0;
    logic rst = 1'h1;
    logic [4:0] addr = 5'h00;
    logic rd = 1'h0;
    logic wr = 1'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] be = 4'hF;
    logic ce = 1'h0;
    logic cs_n = 1'h1;
    logic rc = 1'h1;
    logic fw = 1'h1;
    logic a0 = 1'h0;
    logic irq_exp = 1'h1;
    logic [31:0] rdata;
    logic [31:0] r;
    logic waitreq, irq, busy, settle, comp;
    logic [2:0] oe_n;
    code_t dout, dac;
    code_t early = 12'h000;
    code_t final_v = 12'h000;
    int failures = 0;
    int checked = 0;
    always #50 sys_clk = ~sys_clk;
    error_correcting_sar_control dut_u (.sys_clk_i(sys_clk), .rst_i(rst), .address_i(addr), .read_i(rd),
        .write_i(wr), .writedata_i(wdata), .byteenable_i(be), .readdata_o(rdata), .waitrequest_o(waitreq),
        .irq_o(irq), .chip_enable_i(ce), .chip_select_n_i(cs_n), .read_convert_i(rc), .full_width_i(fw),
        .byte_select_i(a0), .comparator_i(comp), .conversion_busy_o(busy), .data_o(dout),
        .data_oe_n_o(oe_n), .dac_code_o(dac), .dac_settle_fine_o(settle));
    analog_source_model src_u (.sys_clk_i(sys_clk), .busy_i(busy), .dac_code_i(dac), .early_i(early),
        .final_i(final_v), .comparator_o(comp));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic summarize();
        if (failures == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : summarize
    // request held until the edge that sees waitrequest low
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
        int k;
        k = 0;
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        rd <= ~w;
        wr <= w;
        do begin
            @(posedge sys_clk);
            k++;
        end while (waitreq !== 1'h0 && k < 20);
        if (k >= 20) failures++;
        q = rdata;
        rd <= 1'h0;
        wr <= 1'h0;
    endtask : bus
    task automatic run(input logic eight, input logic alone, input code_t v, input code_t e);
        int cnt;
        logic short_conv;
        logic fine_seen;
        code_t x;
        short_conv = eight && !alone;
        x = short_conv ? {v[11:4], `EIGHT_TAIL} : v;
        fine_seen = 1'h0;
        cnt = 0;
        @(posedge sys_clk);
        final_v <= v;
        early <= e;
        a0 <= eight;
        rc <= 1'h0;
        do begin
            @(posedge sys_clk);
            cnt++;
        end while (busy !== 1'h1 && cnt < 5);
        cnt = 0;
        while (busy === 1'h1 && cnt < 200) begin
            @(posedge sys_clk);
            cnt++;
            fine_seen = fine_seen | settle;
            if (cnt == 3) check(settle, 1'h0);
            if (cnt == 4) check(oe_n, `OE_ALL_OFF);
            // fresh start edge while busy must be ignored
            if (cnt == 10 && short_conv) rc <= 1'h1;
            if (cnt == 12 && short_conv) rc <= 1'h0;
        end
        rc <= 1'h1;
        check(fine_seen, !short_conv);
        check(short_conv ? (cnt >= 30 && cnt <= 34) : (cnt >= 71 && cnt <= 77), 1'h1);
        repeat (3) @(posedge sys_clk);
        check(oe_n, `OE_ALL_ON);
        check(dout, x);
        if (!alone) begin
            fw <= 1'h0;
            a0 <= 1'h0;
            repeat (3) @(posedge sys_clk);
            check(oe_n, `OE_MSB_BYTE);
            check(dout[11:4], x[11:4]);
            a0 <= 1'h1;
            repeat (3) @(posedge sys_clk);
            check(oe_n, `OE_LSB_BYTE);
            check(dout[7:0], {4'h0, x[3:0]});
            fw <= 1'h1;
        end
        bus(1'h0, `REG_RESULT, 32'h0, r);
        check(r, {20'h0, x});
        bus(1'h0, `REG_STATUS, 32'h0, r);
        check(r[2:0], {1'h1, short_conv, 1'h0});
        check(irq, irq_exp);
        bus(1'h0, `REG_IRQ_STAT, 32'h0, r);
        check(r[1:0], {short_conv, 1'h1});
        bus(1'h1, `REG_IRQ_STAT, 32'h3, r);
        repeat (3) @(posedge sys_clk);
        check(irq, 1'h0);
    endtask : run
    initial begin
        repeat (4) @(posedge sys_clk);
        rst <= 1'h0;
        check(waitreq, 1'h1);
        check(oe_n, `OE_ALL_OFF);
        check(busy, 1'h0);
        bus(1'h0, `REG_IRQ_MASK, 32'h0, r);
        check(r, 32'h0);
        bus(1'h1, 5'h14, 32'hFFFF_FFFF, r);
        bus(1'h0, 5'h14, 32'h0, r);
        check(r, 32'h0);
        be <= 4'h0;
        bus(1'h1, `REG_CTRL, 32'h1, r);
        be <= 4'hF;
        bus(1'h0, `REG_CTRL, 32'h0, r);
        check(r, 32'h0);
        bus(1'h1, `REG_IRQ_MASK, 32'h1, r);
        ce <= 1'h1;
        cs_n <= 1'h0;
        run(1'h0, 1'h0, 12'h000, 12'h000);
        run(1'h0, 1'h0, 12'hFFF, 12'hFFF);
        run(1'h0, 1'h0, 12'hA5C, 12'hA5C);
        run(1'h0, 1'h0, 12'h5A7, 12'h5C7);
        run(1'h0, 1'h0, 12'h5A7, 12'h597);
        run(1'h1, 1'h0, 12'h5A7, 12'h5A7);
        // masked done event leaves the interrupt line low
        bus(1'h1, `REG_IRQ_MASK, 32'h0, r);
        irq_exp = 1'h0;
        bus(1'h1, `REG_CTRL, 32'h1, r);
        bus(1'h0, `REG_CTRL, 32'h0, r);
        check(r, 32'h1);
        ce <= 1'h0;
        cs_n <= 1'h1;
        fw <= 1'h0;
        run(1'h1, 1'h1, 12'h3C1, 12'h3C1);
        summarize();
    end
    initial begin
        #(30000 * 100);
        failures++;
        summarize();
    end
endmodule : error_correcting_sar_control_bench
`default_nettype wire
